/* hdl/fcp_array.sv */
/*
  Flash cell array model: halfword words with byte-lane writes, registered read.
  Assumes one access per cycle; contents are not defined after power-up.
*/
module fcp_array #(
  parameter int WORDS = 65536,
  parameter int AW    = $clog2(WORDS)
) (
  // clock
  input  wire logic          sys_clk,
  // access
  input  wire logic          wrEn,
  input  wire logic [1:0]    byteEn,
  input  wire logic [AW-1:0] addr,
  input  wire logic [15:0]   wdata,
  output logic      [15:0]   rdata_q
);
  // one byte array per lane so each lane has a single writing process
  for (genvar b = 0; b < 2; b++) begin : g_lane
    logic [7:0] mem [WORDS];

    always_ff @(posedge sys_clk) begin
      if (wrEn && byteEn[b]) begin
        mem[addr] <= wdata[8*b +: 8];
      end
      rdata_q[8*b +: 8] <= mem[addr];
    end
  end
endmodule

/* hdl/fcp_flash_if.sv */
/*
  Flash program interface top: CPU read/command port, programmer address path,
  automatic program/erase sequencer with suspend, polling status and the
  control/status register on AXI4-Lite.
  Assumes CPU strobes, programmer select and the bus all run on sys_clk.
*/
// Our own choices: register access over AXI4-Lite and the address map.
module fcp_flash_if #(
  parameter int TICK_CYC   = fcp_pkg::TICK_CYC,
  parameter int EWIN_TICKS = fcp_pkg::EWIN_TICKS,
  parameter int WORDS      = fcp_pkg::ARRAY_WORDS
) (
  // clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  // AXI4-Lite register slave
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [fcp_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]                s_axi_awprot,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  output logic      [1:0]                s_axi_bresp,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  input  wire logic [fcp_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic [2:0]                s_axi_arprot,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic      [31:0]               s_axi_rdata,
  output logic      [1:0]                s_axi_rresp,
  // CPU flash port
  input  wire logic                      cpuReq,
  input  wire logic                      cpuWrite,
  input  wire logic                      cpuWide,
  input  wire logic [23:0]               cpuAddr,
  input  wire logic [15:0]               cpuWdata,
  output logic                           cpuReady,
  output logic                           cpuAck,
  output logic      [15:0]               cpuRdata,
  // programmer address path
  input  wire logic                      pgmSel,
  input  wire logic [18:0]               pgmAddr,
  // interrupt
  output logic                           flashIrq
);
  localparam int AW = $clog2(WORDS);

  // ==========================================================
  // sector decode
  // sector boundaries
  function automatic logic [1:0] secOf(input logic [15:0] o);
    if (o >= fcp_pkg::SEC3_BASE) begin
      secOf = 2'd3;
    end else if (o >= fcp_pkg::SEC2_BASE) begin
      secOf = 2'd2;
    end else if (o >= fcp_pkg::SEC1_BASE) begin
      secOf = 2'd1;
    end else begin
      secOf = 2'd0;
    end
  endfunction

  // ==========================================================
  // state
  fcp_pkg::fcp_state_e state_q, state_d;
  logic [2:0]    cmdPh_q, cmdPh_d;
  logic [3:0]    secMask_q, secMask_d;
  logic [AW-1:0] progIdx_q, progIdx_d;
  logic [15:0]   progData_q, progData_d;
  logic [1:0]    progBe_q, progBe_d;
  logic [14:0]   walk_q, walk_d;
  logic [15:0]   winCnt_q, winCnt_d;
  logic          tog6_q, tog6_d, tog2_q, tog2_d;
  logic          rdPend_q, rdPend_d, rdStat_q, rdStat_d;
  logic          rdWide_q, rdWide_d, rdHi_q, rdHi_d;
  logic [7:0]    statByte_q, statByte_d;
  logic [15:0]   cpuRdata_q, cpuRdata_d;
  logic          cpuAck_q, cpuAck_d;
  logic          irqEn_q, irqEn_d, cmdEn_q, cmdEn_d, done_q, done_d;
  logic          awHave_q, awHave_d, wHave_q, wHave_d;
  logic [fcp_pkg::AXI_AW-1:0] awAddr_q, awAddr_d;
  logic [31:0]   wData_q, wData_d;
  logic [3:0]    wStrb_q, wStrb_d;
  logic          bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]    bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]   rdata_q, rdata_d;

  // ==========================================================
  // combinational helpers
  logic          inRange, take, busyRead, regWr, tick, runTick;
  logic          memWe, evDone;
  logic [15:0]   off, memQ, memWdata;
  logic [1:0]    memBe;
  logic [AW-1:0] memAddr;
  logic [7:0]    cd, fcs;
  logic          walkHit, walkLast;

  assign inRange = pgmSel ? (pgmAddr[18:16] == fcp_pkg::PGM_TOP) : (cpuAddr[23:16] == fcp_pkg::BANK_TOP);
  assign off     = pgmSel ? pgmAddr[15:0] : cpuAddr[15:0];
  assign cd      = cpuWdata[7:0];
  assign cpuReady = !rdPend_q && !cpuAck_q;
  assign take    = cpuReq && cpuReady;
  assign runTick = (state_q == fcp_pkg::ST_PROG) || (state_q == fcp_pkg::ST_EWIN)
                   || (state_q == fcp_pkg::ST_ERASE);
  assign busyRead = runTick || ((state_q == fcp_pkg::ST_SUSP) && secMask_q[secOf(off)]);
  assign regWr   = awHave_q && wHave_q && !bvalid_q;
  assign walkHit = secMask_q[secOf({walk_q, 1'b0})];
  assign walkLast = (walk_q == '1);
  // bit 4 tracks readiness; all stored bits reset to zero
  assign fcs = {irqEn_q, cmdEn_q, done_q,
                (state_q == fcp_pkg::ST_IDLE) || (state_q == fcp_pkg::ST_SUSP),
                (state_q == fcp_pkg::ST_SUSP), 3'b000};

  fcp_tick #(
    .DIV (TICK_CYC)
  ) u_tick (
    .sys_clk (sys_clk),
    .rst     (rst),
    .run     (runTick),
    .tick    (tick)
  );

  // one array port for reads and sequencer writes
  always_comb begin
    memWe    = 1'b0;
    memBe    = 2'b11;
    memWdata = 16'hFFFF;
    memAddr  = AW'({1'b0, off[15:1]});
    if (state_q == fcp_pkg::ST_PROG && tick) begin
      memWe    = 1'b1;
      memBe    = progBe_q;
      memWdata = progData_q;
      memAddr  = progIdx_q;
    end else if (state_q == fcp_pkg::ST_ERASE && walkHit && tick) begin
      memWe   = 1'b1;
      memAddr = AW'(walk_q);
    end
  end

  fcp_array #(
    .WORDS (WORDS),
    .AW    (AW)
  ) u_array (
    .sys_clk (sys_clk),
    .wrEn    (memWe),
    .byteEn  (memBe),
    .addr    (memAddr),
    .wdata   (memWdata),
    .rdata_q (memQ)
  );

  // ==========================================================
  // AXI4-Lite slave
  always_comb begin
    awHave_d = awHave_q;
    awAddr_d = awAddr_q;
    wHave_d  = wHave_q;
    wData_d  = wData_q;
    wStrb_d  = wStrb_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    s_axi_awready = !awHave_q && !bvalid_q;
    s_axi_wready  = !wHave_q && !bvalid_q;
    s_axi_arready = !rvalid_q;
    if (s_axi_awvalid && s_axi_awready) begin
      awHave_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHave_d = 1'b1;
      wData_d = s_axi_wdata;
      wStrb_d = s_axi_wstrb;
    end
    if (regWr) begin
      awHave_d = 1'b0;
      wHave_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = (awAddr_q == fcp_pkg::FCS_OFF) ? fcp_pkg::RESP_OK : fcp_pkg::RESP_ERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = (s_axi_araddr == fcp_pkg::FCS_OFF) ? fcp_pkg::RESP_OK : fcp_pkg::RESP_ERR;
      rdata_d  = (s_axi_araddr == fcp_pkg::FCS_OFF) ? {24'h00_0000, fcs} : 32'h0000_0000;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      awHave_q <= 1'b0;
      awAddr_q <= '0;
      wHave_q  <= 1'b0;
      wData_q  <= '0;
      wStrb_q  <= '0;
      bvalid_q <= 1'b0;
      bresp_q  <= fcp_pkg::RESP_OK;
      rvalid_q <= 1'b0;
      rresp_q  <= fcp_pkg::RESP_OK;
      rdata_q  <= '0;
    end else begin
      awHave_q <= awHave_d;
      awAddr_q <= awAddr_d;
      wHave_q  <= wHave_d;
      wData_q  <= wData_d;
      wStrb_q  <= wStrb_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q  <= rresp_d;
      rdata_q  <= rdata_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = rdata_q;

  // ==========================================================
  // CPU port, command decoder and sequencer
  always_comb begin
    state_d    = state_q;
    cmdPh_d    = cmdPh_q;
    secMask_d  = secMask_q;
    progIdx_d  = progIdx_q;
    progData_d = progData_q;
    progBe_d   = progBe_q;
    walk_d     = walk_q;
    winCnt_d   = winCnt_q;
    tog6_d     = tog6_q;
    tog2_d     = tog2_q;
    rdPend_d   = 1'b0;
    rdStat_d   = rdStat_q;
    rdWide_d   = rdWide_q;
    rdHi_d     = rdHi_q;
    statByte_d = statByte_q;
    cpuRdata_d = cpuRdata_q;
    cpuAck_d   = 1'b0;
    irqEn_d    = irqEn_q;
    cmdEn_d    = cmdEn_q;
    done_d     = done_q;
    evDone     = 1'b0;

    // read: array data next cycle, or status while busy
    if (take && !cpuWrite) begin
      rdPend_d = 1'b1;
      rdStat_d = busyRead || !inRange;
      rdWide_d = cpuWide;
      rdHi_d   = off[0];
      // polling byte: inverted bit 7, toggles on 6 and 2, window on 3
      statByte_d = 8'h00;
      if (inRange && busyRead) begin
        statByte_d[7] = (state_q == fcp_pkg::ST_PROG) ? ~progData_q[{progBe_q[1], 3'd7}]
                        : (state_q == fcp_pkg::ST_SUSP);
        statByte_d[6] = tog6_q;
        statByte_d[3] = (state_q == fcp_pkg::ST_ERASE) || (state_q == fcp_pkg::ST_SUSP);
        statByte_d[2] = tog2_q;
        if (state_q != fcp_pkg::ST_SUSP) begin
          tog6_d = !tog6_q;
        end
        if (state_q != fcp_pkg::ST_PROG) begin
          tog2_d = !tog2_q;
        end
      end
    end
    if (rdPend_q) begin
      cpuAck_d = 1'b1;
      // halfword or single byte on the low lane
      if (rdStat_q) begin
        cpuRdata_d = {8'h00, statByte_q};
      end else if (rdWide_q) begin
        cpuRdata_d = memQ;
      end else begin
        cpuRdata_d = {8'h00, rdHi_q ? memQ[15:8] : memQ[7:0]};
      end
    end

    // unlock sequence, anything unexpected drops back
    if (take && cpuWrite) begin
      cpuAck_d = 1'b1;
      if (inRange && cmdEn_q) begin
        if (state_q == fcp_pkg::ST_IDLE) begin
          cmdPh_d = 3'd0;
          case (cmdPh_q)
            3'd0: if (cd == fcp_pkg::CMD_UNL1 && off == fcp_pkg::UNLOCK_A) cmdPh_d = 3'd1;
            3'd1: if (cd == fcp_pkg::CMD_UNL2 && off == fcp_pkg::UNLOCK_B) cmdPh_d = 3'd2;
            // identification codes fall through and are dropped
            3'd2: begin
              if (off == fcp_pkg::UNLOCK_A && cd == fcp_pkg::CMD_PROG) cmdPh_d = 3'd3;
              if (off == fcp_pkg::UNLOCK_A && cd == fcp_pkg::CMD_ERASE) cmdPh_d = 3'd4;
            end
            // data write launches the program sequence
            3'd3: begin
              state_d    = fcp_pkg::ST_PROG;
              progIdx_d  = AW'({1'b0, off[15:1]});
              progData_d = cpuWide ? cpuWdata : {cd, cd};
              progBe_d   = cpuWide ? 2'b11 : (off[0] ? 2'b10 : 2'b01);
            end
            3'd4: if (cd == fcp_pkg::CMD_UNL1 && off == fcp_pkg::UNLOCK_A) cmdPh_d = 3'd5;
            3'd5: if (cd == fcp_pkg::CMD_UNL2 && off == fcp_pkg::UNLOCK_B) cmdPh_d = 3'd6;
            3'd6: begin
              if (cd == fcp_pkg::CMD_CHIP && off == fcp_pkg::UNLOCK_A) begin
                secMask_d = 4'hF;
                state_d   = fcp_pkg::ST_ERASE;
                walk_d    = '0;
              end else if (cd == fcp_pkg::CMD_SECT) begin
                secMask_d = 4'h1 << secOf(off);
                state_d   = fcp_pkg::ST_EWIN;
                winCnt_d  = '0;
              end
            end
            default: cmdPh_d = 3'd0;
          endcase
        end else if (state_q == fcp_pkg::ST_EWIN && cd == fcp_pkg::CMD_SECT) begin
          // further sectors join while the window is open
          secMask_d = secMask_q | (4'h1 << secOf(off));
          winCnt_d  = '0;
        end else if (state_q == fcp_pkg::ST_ERASE && cd == fcp_pkg::CMD_SUSP) begin
          state_d = fcp_pkg::ST_SUSP;
        end else if (state_q == fcp_pkg::ST_SUSP && cd == fcp_pkg::CMD_SECT) begin
          state_d = fcp_pkg::ST_ERASE;
        end
        if (cd == fcp_pkg::CMD_RST && state_q == fcp_pkg::ST_IDLE) begin
          cmdPh_d = 3'd0;
        end
      end
    end

    // automatic algorithm
    case (state_q)
      fcp_pkg::ST_IDLE: begin
      end
      fcp_pkg::ST_PROG: begin
        if (tick) begin
          state_d = fcp_pkg::ST_IDLE;
          evDone  = 1'b1;
        end
      end
      fcp_pkg::ST_EWIN: begin
        if (tick && !(take && cpuWrite)) begin
          winCnt_d = winCnt_q + 16'h0001;
          if (winCnt_q == 16'(EWIN_TICKS - 1)) begin
            state_d = fcp_pkg::ST_ERASE;
            walk_d  = '0;
          end
        end
      end
      fcp_pkg::ST_ERASE: begin
        // unselected words are skipped at full speed
        if (!walkHit || tick) begin
          walk_d = walk_q + 15'h0001;
          if (walkLast) begin
            state_d   = fcp_pkg::ST_IDLE;
            secMask_d = 4'h0;
            evDone    = 1'b1;
          end
        end
        if (state_d == fcp_pkg::ST_SUSP) begin
          walk_d = walk_q;
        end
      end
      fcp_pkg::ST_SUSP: begin
      end
      default: state_d = fcp_pkg::ST_IDLE;
    endcase

    // control/status write; completion wins over a clear
    if (regWr && awAddr_q == fcp_pkg::FCS_OFF && wStrb_q[0]) begin
      irqEn_d = wData_q[fcp_pkg::FCS_IRQEN];
      cmdEn_d = wData_q[fcp_pkg::FCS_CMDEN];
      if (!wData_q[fcp_pkg::FCS_DONE]) begin
        done_d = 1'b0;
      end
    end
    if (evDone) begin
      done_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q    <= fcp_pkg::ST_IDLE;
      cmdPh_q    <= '0;
      secMask_q  <= '0;
      progIdx_q  <= '0;
      progData_q <= '0;
      progBe_q   <= '0;
      walk_q     <= '0;
      winCnt_q   <= '0;
      tog6_q     <= 1'b0;
      tog2_q     <= 1'b0;
      rdPend_q   <= 1'b0;
      rdStat_q   <= 1'b0;
      rdWide_q   <= 1'b0;
      rdHi_q     <= 1'b0;
      statByte_q <= '0;
      cpuRdata_q <= '0;
      cpuAck_q   <= 1'b0;
      irqEn_q    <= 1'b0;
      cmdEn_q    <= 1'b0;
      done_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      cmdPh_q    <= cmdPh_d;
      secMask_q  <= secMask_d;
      progIdx_q  <= progIdx_d;
      progData_q <= progData_d;
      progBe_q   <= progBe_d;
      walk_q     <= walk_d;
      winCnt_q   <= winCnt_d;
      tog6_q     <= tog6_d;
      tog2_q     <= tog2_d;
      rdPend_q   <= rdPend_d;
      rdStat_q   <= rdStat_d;
      rdWide_q   <= rdWide_d;
      rdHi_q     <= rdHi_d;
      statByte_q <= statByte_d;
      cpuRdata_q <= cpuRdata_d;
      cpuAck_q   <= cpuAck_d;
      irqEn_q    <= irqEn_d;
      cmdEn_q    <= cmdEn_d;
      done_q     <= done_d;
    end
  end

  assign cpuAck   = cpuAck_q;
  assign cpuRdata = cpuRdata_q;
  assign flashIrq = irqEn_q && done_q;
endmodule

/* hdl/fcp_pkg.sv */
/*
  Shared constants for the on-chip flash program interface: bank and sector map,
  command codes, control/status layout, timing and sequencer states.
  Assumes a 200 MHz sys_clk and a 4-bit AXI4-Lite register window.
*/
package fcp_pkg;
  // ==========================================================
  // timing
  localparam int CLK_NS     = 5;
  localparam int TICK_NS    = 100;
  localparam int TICK_CYC   = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int EWIN_US    = 50;
  localparam int EWIN_TICKS = (EWIN_US * 1000) / TICK_NS;
  // ==========================================================
  // array map
  localparam int          ARRAY_WORDS = 65536;
  localparam logic [7:0]  BANK_TOP    = 8'hFF;
  localparam logic [2:0]  PGM_TOP     = 3'h7;
  localparam logic [15:0] SEC1_BASE   = 16'h8000;
  localparam logic [15:0] SEC2_BASE   = 16'hA000;
  localparam logic [15:0] SEC3_BASE   = 16'hC000;
  localparam logic [15:0] UNLOCK_A    = 16'h0AAA;
  localparam logic [15:0] UNLOCK_B    = 16'h0554;
  // ==========================================================
  // command codes
  localparam logic [7:0] CMD_UNL1  = 8'hAA;
  localparam logic [7:0] CMD_UNL2  = 8'h55;
  localparam logic [7:0] CMD_PROG  = 8'hA0;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_CHIP  = 8'h10;
  localparam logic [7:0] CMD_SECT  = 8'h30;
  localparam logic [7:0] CMD_SUSP  = 8'hB0;
  localparam logic [7:0] CMD_RST   = 8'hF0;
  // ==========================================================
  // register window
  localparam int         AXI_AW    = 4;
  localparam logic [3:0] FCS_OFF   = 4'h0;
  localparam int         FCS_IRQEN = 7;
  localparam int         FCS_CMDEN = 6;
  localparam int         FCS_DONE  = 5;
  localparam int         FCS_RDY   = 4;
  localparam int         FCS_SUSP  = 3;
  localparam logic [1:0] RESP_OK   = 2'h0;
  localparam logic [1:0] RESP_ERR  = 2'h2;
  // ==========================================================
  // sequencer states
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_PROG  = 5'b00010,
    ST_EWIN  = 5'b00100,
    ST_ERASE = 5'b01000,
    ST_SUSP  = 5'b10000
  } fcp_state_e;
endpackage

/* hdl/fcp_tick.sv */
/*
  Pacing divider: one-cycle tick every DIV cycles while run is high.
  Assumes run comes from logic on sys_clk.
*/
module fcp_tick #(
  parameter int DIV = 20
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // control
  input  wire logic run,
  output logic      tick
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    tick  = 1'b0;
    if (!run) begin
      cnt_d = '0;
    end else if (cnt_q == 16'(DIV - 1)) begin
      cnt_d = '0;
      tick  = 1'b1;
    end else begin
      cnt_d = cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

/* verif/fcp_cpu_model.sv */
/*
  CPU model issuing single flash port requests.
  Assumes access() is called right after a rising edge.
*/
module fcp_cpu_model (
  // clock
  input wire logic sys_clk,
  // flash port
  output logic cpuReq,
  output logic cpuWrite,
  output logic cpuWide,
  output logic [23:0] cpuAddr,
  output logic [15:0] cpuWdata,
  input wire logic cpuReady,
  input wire logic cpuAck,
  input wire logic [15:0] cpuRdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cpuReq = 1'b0;
    cpuWrite = 1'b0;
    cpuWide = 1'b0;
    cpuAddr = 24'h00_0000;
    cpuWdata = 16'h0000;
  end
  task automatic access(input logic wr, wd, input logic [23:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic ok);
    logic tk;
    tk = 1'b0;
    ok = 1'b0;
    q = 16'h0000;
    cpuReq <= 1'b1;
    cpuWrite <= wr;
    cpuWide <= wd;
    cpuAddr <= a;
    cpuWdata <= d;
    for (int k = 0; k < 50 && !ok; k++) begin
      @(posedge sys_clk);
      if (tk && cpuAck) begin
        ok = 1'b1;
        q = cpuRdata;
      end
      if (!tk && cpuReady) begin
        tk = 1'b1;
        cpuReq <= 1'b0;
        // released lines must not keep last value
        cpuAddr <= ~a;
        cpuWdata <= ~d;
      end
    end
  endtask
endmodule

/* verif/fcp_flash_if_bench.sv */
/*
  Bench for fcp_flash_if: registers, program, bad sequence, erase with suspend.
  Assumes short pacing parameters.
*/
module fcp_flash_if_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, pgmSel;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, flashIrq;
  logic cpuReq, cpuWrite, cpuWide, cpuReady, cpuAck, ok;
  logic [3:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [23:0] cpuAddr;
  logic [15:0] cpuWdata, cpuRdata, q, q2;
  logic [18:0] pgmAddr;
  int errors, n_tests;
  fcp_flash_if #(.TICK_CYC(2), .EWIN_TICKS(4)) i_fcp_flash_if (.sys_clk, .rst, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .cpuReq,
    .cpuWrite, .cpuWide, .cpuAddr, .cpuWdata, .cpuReady, .cpuAck, .cpuRdata, .pgmSel, .pgmAddr, .flashIrq);
  fcp_cpu_model i_fcp_cpu_model (.sys_clk, .cpuReq, .cpuWrite, .cpuWide, .cpuAddr, .cpuWdata, .cpuReady,
    .cpuAck, .cpuRdata);
  task automatic chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic tmo;
    errors++;
    $display("[ERR] %0t no answer", $time);
    report_and_stop();
  endtask
  task automatic axw(input logic [3:0] a, input logic [7:0] d);
    int k;
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= 32'(d);
    s_axi_bready <= 1'b1;
    for (k = 0; k < 40 && !s_axi_bvalid; k++) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    if (k == 40) tmo();
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic axr(input logic [3:0] a);
    int k;
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 40 && !s_axi_rvalid; k++) begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    if (k == 40) tmo();
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic waitbit(input int b, input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      axr(4'h0);
      if (v[b] === 1'b1) break;
    end
    if (k == lim) tmo();
  endtask
  task automatic cpu(input logic wr, wd, input logic [15:0] a, d);
    i_fcp_cpu_model.access(wr, wd, {8'hFF, a}, d, q, ok);
    if (!ok) tmo();
  endtask
  task automatic unl;
    cpu(1, 1, 16'h0AAA, 16'h00AA);
    cpu(1, 1, 16'h0554, 16'h0055);
  endtask
  task automatic t_reg;
    axr(4'h0);
    chk(v, 32'h0000_0010);
    axr(4'h8);
    chk(v, 32'h0000_0000);
    chk(32'(resp), 32'(fcp_pkg::RESP_ERR));
    axw(4'h4, 8'hFF);
    chk(resp, fcp_pkg::RESP_ERR);
    $display("t_reg done");
  endtask
  task automatic t_prog;
    axw(4'h0, 8'hC0);
    unl();
    cpu(1, 1, 16'h0AAA, 16'h00A0);
    cpu(1, 1, 16'h0100, 16'h1234);
    waitbit(fcp_pkg::FCS_DONE, 20);
    chk(flashIrq, 1'b1);
    cpu(0, 1, 16'h0100, 16'h0000);
    chk(q, 16'h1234);
    cpu(0, 0, 16'h0101, 16'h0000);
    chk(q, 16'h0012);
    pgmSel <= 1'b1;
    pgmAddr <= 19'h7_0100;
    cpu(0, 1, 16'h0000, 16'h0000);
    pgmSel <= 1'b0;
    chk(q, 16'h1234);
    axw(4'h0, 8'hC0);
    chk(flashIrq, 1'b0);
    $display("t_prog done");
  endtask
  task automatic t_bad;
    unl();
    cpu(1, 1, 16'h0AAA, 16'h0090);
    cpu(1, 1, 16'h0AAA, 16'h00A0);
    cpu(1, 1, 16'h0100, 16'h5555);
    cpu(0, 1, 16'h0100, 16'h0000);
    chk(q, 16'h1234);
    $display("t_bad done");
  endtask
  task automatic t_erase;
    unl();
    cpu(1, 1, 16'h0AAA, 16'h0080);
    unl();
    cpu(1, 1, 16'h8000, 16'h0030);
    // second sector joins while the start window is open
    cpu(1, 1, 16'hA000, 16'h0030);
    cpu(0, 1, 16'h8000, 16'h0000);
    q2 = q;
    cpu(0, 1, 16'h8000, 16'h0000);
    chk({q[7], q[2] ^ q2[2]}, 2'b01);
    // let the start window run out
    repeat (12) @(posedge sys_clk);
    cpu(1, 1, 16'h0AAA, 16'h00B0);
    waitbit(fcp_pkg::FCS_SUSP, 40);
    chk(v[fcp_pkg::FCS_RDY], 1'b1);
    cpu(0, 1, 16'h0100, 16'h0000);
    chk(q, 16'h1234);
    cpu(1, 1, 16'h0AAA, 16'h0030);
    waitbit(fcp_pkg::FCS_DONE, 20000);
    chk(flashIrq, 1'b1);
    cpu(0, 1, 16'h0100, 16'h0000);
    chk(q, 16'h1234);
    cpu(0, 1, 16'h8000, 16'h0000);
    chk(q, 16'hFFFF);
    cpu(0, 1, 16'hA000, 16'h0000);
    chk(q, 16'hFFFF);
    $display("t_erase done");
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, pgmSel} = 7'h7F ^ 7'h3F;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pgmAddr} = '0;
    errors = 0;
    n_tests = 0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reg();
    t_prog();
    t_bad();
    t_erase();
    report_and_stop();
  end
endmodule

/* verif/fcp_flash_if_sva.sv */
/*
  Port checker for fcp_flash_if.
  Assumes a bind onto every fcp_flash_if instance.
*/
module fcp_flash_if_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  // cpu port
  input wire logic cpuReq,
  input wire logic cpuReady,
  input wire logic cpuWrite,
  input wire logic cpuAck,
  input wire logic flashIrq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========
  // register bus
  bresp_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp lost");
  wr_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##1 !s_axi_bvalid ##1
      s_axi_bvalid && s_axi_bresp == ($past(s_axi_awaddr, 2) == 4'h0 ? 2'h0 : 2'h2)) else $error("bad write answer");
  wr_refuse_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  rd_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000)
      else $error("bad read answer");
  rd_refuse_a:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  // ==========
  // cpu port
  cpu_wack_a:
    assert property (cpuReq && cpuReady && cpuWrite |=> cpuAck) else $error("write ack late");
  cpu_rack_a:
    assert property (cpuReq && cpuReady && !cpuWrite |=> !cpuAck ##1 cpuAck) else $error("read ack wrong");
  reset_quiet_a:
    assert property (disable iff (1'b0) rst |=> !s_axi_bvalid && !s_axi_rvalid && !cpuAck && !flashIrq)
      else $error("busy after reset");
endmodule
bind fcp_flash_if fcp_flash_if_sva i_sva (.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rdata, .cpuReq, .cpuReady, .cpuWrite, .cpuAck, .flashIrq);
